// ### shared/idle_reset_consts.svh
// Offsets, field positions, reset values and timing counts of the idle and reset controller
`ifndef IDLE_RESET_CONSTS_SVH
`define IDLE_RESET_CONSTS_SVH
// Register indices; the byte address is four times the index
`define REG_PWR_CTRL_IDX 8'h00
`define REG_WDT_CTRL_IDX 8'h01
`define REG_IRQ_STAT_IDX 8'h02
`define REG_IRQ_MASK_IDX 8'h03
`define REG_RST_CAUSE_IDX 8'hEF
// Power control fields
`define PWR_IDLE_BIT 0
// Reset cause fields
`define CAUSE_PIN_BIT 0
`define CAUSE_POR_BIT 1
`define CAUSE_MCD_BIT 2
`define CAUSE_WDT_BIT 3
`define CAUSE_SOFT_BIT 4
`define CAUSE_CMP_BIT 5
`define CAUSE_FERR_BIT 6
// Watchdog control fields
`define WDT_EN_BIT 0
`define WDT_LOCK_BIT 1
`define WDT_KICK_BIT 2
// Interrupt status fields
`define IRQ_IDLE_BIT 0
`define IRQ_WAKE_BIT 1
`define IRQ_RST_BIT 2
// Reset values
`define PWR_CTRL_RST 8'h00
`define CAUSE_POR_RST 8'h02
`define WDT_CTRL_RST 8'h01
`define IRQ_RST_VAL 8'h00
`define RESET_VECTOR 16'h0000
// Timing
`define CLK_PERIOD_NS 20
`define RST_HOLD_NS 100
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_TIMEOUT_DEF 65536
`endif

// ### shared/idle_reset_pkg.sv
// Types shared by the idle and reset controller
package idle_reset_pkg;
  // Sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_ARMED, ST_IDLE, ST_RESET} pwr_state_t;

  // Reset sources arriving from the rest of the chip
  typedef struct packed {
    logic flash_error;
    logic comparator;
    logic missing_clock;
    logic vdd_monitor;
    logic pin;
  } reset_sources_t;

  // CPU side handshake
  typedef struct packed {
    logic instr_done;
    logic next_single_byte;
  } cpu_status_t;
endpackage

// ### hdl/idle_reset_ctrl.sv
// CPU idle mode, watchdog, software reset and reset cause recording behind an AXI4-Lite slave
`include "idle_reset_consts.svh"

module idle_reset_ctrl #(
  parameter int N_IRQ = 8,
  parameter int WDT_TIMEOUT_CYCLES = `WDT_TIMEOUT_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Chip side
  input wire logic [N_IRQ-1:0] irq_pending_in,
  input wire logic [N_IRQ-1:0] irq_enable_in,
  input wire idle_reset_pkg::cpu_status_t cpu_status_in,
  input wire idle_reset_pkg::reset_sources_t reset_sources_in,
  output logic cpu_halt_out,
  output logic wake_irq_out,
  output logic dev_reset_out,
  output logic [15:0] reset_vector_out,
  output logic irq_out
);

  localparam int WDT_W = $clog2(WDT_TIMEOUT_CYCLES + 1);
  localparam logic [3:0] RST_HOLD = 4'(`RST_HOLD_CYC);

  // Refuse shapes the logic cannot serve; caught at elaboration, not at run time
  if (N_IRQ < 1 || WDT_TIMEOUT_CYCLES < 2 || `RST_HOLD_CYC > 15)
  begin : g_bad_param
    $error("idle_reset_ctrl: bad parameter");
  end

  idle_reset_pkg::pwr_state_t state_q;
  logic idle_sel_q;
  logic wake_blocked_q;
  logic armed_irq_q;
  logic [7:0] cause_q;
  logic cmp_en_q;
  logic mcd_en_q;
  logic vdd_en_q;
  logic wdt_en_q;
  logic wdt_lock_q;
  logic [WDT_W-1:0] wdt_cnt_q;
  logic [3:0] rst_cnt_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [11:0] aw_addr_q;
  logic aw_held_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic w_held_q;
  logic [31:0] rd_data_d;
  logic rd_hit_d;
  logic wr_go;
  logic wr_en;
  logic [7:0] wr_idx;
  logic irq_wake;
  logic wdt_fire;
  logic [7:0] cause_d;
  logic rst_trig;
  logic soft_rst;
  logic [2:0] irq_set;

  // Write happens once both address and data are held and no response waits
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid_out;
  assign wr_en = wr_go && w_strb_q && (aw_addr_q[1:0] == 2'b00);
  assign wr_idx = aw_addr_q[9:2];
  assign irq_wake = |(irq_pending_in & irq_enable_in);

  assign soft_rst = wr_en && (wr_idx == `REG_RST_CAUSE_IDX) && w_data_q[`CAUSE_SOFT_BIT];

  assign wdt_fire = wdt_en_q && (wdt_cnt_q == WDT_W'(WDT_TIMEOUT_CYCLES - 1));

  // one flag per source, bit 7 held at zero
  always_comb
  begin
    cause_d = 8'h00;
    if (reset_sources_in.vdd_monitor && vdd_en_q)
    begin
      cause_d[`CAUSE_POR_BIT] = 1'b1;
    end
    else if (reset_sources_in.pin)
    begin
      // pin flag set only for pin reset
      cause_d[`CAUSE_PIN_BIT] = 1'b1;
    end
    else if (reset_sources_in.missing_clock && mcd_en_q)
    begin
      cause_d[`CAUSE_MCD_BIT] = 1'b1;
    end
    else if (wdt_fire)
    begin
      cause_d[`CAUSE_WDT_BIT] = 1'b1;
    end
    else if (reset_sources_in.comparator && cmp_en_q)
    begin
      cause_d[`CAUSE_CMP_BIT] = 1'b1;
    end
    else if (reset_sources_in.flash_error)
    begin
      cause_d[`CAUSE_FERR_BIT] = 1'b1;
    end
    else if (soft_rst)
    begin
      cause_d[`CAUSE_SOFT_BIT] = 1'b1;
    end
  end

  assign rst_trig = |cause_d;

  // AXI write channels; address and data are taken in either order
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end
    else if (ce_in)
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_addr_q <= s_axi_awaddr_in;
        aw_held_q <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_data_q <= s_axi_wdata_in[7:0];
        w_strb_q <= s_axi_wstrb_in[0];
        w_held_q <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        // Unmapped word answers SLVERR
        s_axi_bresp_out <= (wr_idx == `REG_PWR_CTRL_IDX || wr_idx == `REG_WDT_CTRL_IDX ||
                            wr_idx == `REG_IRQ_STAT_IDX || wr_idx == `REG_IRQ_MASK_IDX ||
                            wr_idx == `REG_RST_CAUSE_IDX) && aw_addr_q[11:10] == 2'b00 ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Read decode; reserved bits read zero
  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    rd_hit_d = (s_axi_araddr_in[11:10] == 2'b00);
    case (s_axi_araddr_in[9:2])
      `REG_PWR_CTRL_IDX: rd_data_d[`PWR_IDLE_BIT] = idle_sel_q;
      `REG_WDT_CTRL_IDX: rd_data_d[2:0] = {1'b0, wdt_lock_q, wdt_en_q};
      `REG_IRQ_STAT_IDX: rd_data_d[2:0] = irq_stat_q;
      `REG_IRQ_MASK_IDX: rd_data_d[2:0] = irq_mask_q;
      `REG_RST_CAUSE_IDX: rd_data_d[7:0] = {1'b0, cause_q[6:0]};
      default: rd_hit_d = 1'b0;
    endcase
  end

  // AXI read channel, answer one cycle after the address is taken
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= 2'b00;
    end
    else if (ce_in)
    begin
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_hit_d ? rd_data_d : 32'h0000_0000;
        s_axi_rresp_out <= rd_hit_d ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Reset cause record and source enables; the power-on reset marks the power-on flag
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cause_q <= `CAUSE_POR_RST;
      cmp_en_q <= 1'b0;
      mcd_en_q <= 1'b0;
      vdd_en_q <= 1'b1;
    end
    else if (ce_in)
    begin
      if (rst_trig)
      begin
        cause_q <= cause_d;
      end
      if (wr_en && wr_idx == `REG_RST_CAUSE_IDX)
      begin
        cmp_en_q <= w_data_q[`CAUSE_CMP_BIT];
        mcd_en_q <= w_data_q[`CAUSE_MCD_BIT];
        vdd_en_q <= w_data_q[`CAUSE_POR_BIT];
      end
    end
  end

  // Reset sequence; held for a fixed time, then the CPU starts at the vector
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      rst_cnt_q <= RST_HOLD;
      dev_reset_out <= 1'b1;
      reset_vector_out <= `RESET_VECTOR;
    end
    else if (ce_in)
    begin
      if (rst_trig)
      begin
        // internal reset only, no pin drive
        rst_cnt_q <= RST_HOLD;
        dev_reset_out <= 1'b1;
      end
      else if (rst_cnt_q != 4'h0)
      begin
        rst_cnt_q <= rst_cnt_q - 4'h1;
        dev_reset_out <= (rst_cnt_q != 4'h1);
      end
      reset_vector_out <= `RESET_VECTOR;
    end
  end

  // Idle sequencer; only the CPU is halted, peripherals and the watchdog keep their clock
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= idle_reset_pkg::ST_RESET;
      idle_sel_q <= 1'(`PWR_CTRL_RST);
      wake_blocked_q <= 1'b0;
      armed_irq_q <= 1'b0;
      cpu_halt_out <= 1'b1;
      wake_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      wake_irq_out <= 1'b0;
      if (rst_trig)
      begin
        state_q <= idle_reset_pkg::ST_RESET;
        idle_sel_q <= 1'b0;
        wake_blocked_q <= 1'b0;
        armed_irq_q <= 1'b0;
        cpu_halt_out <= 1'b1;
      end
      else
      begin
        case (state_q)
          idle_reset_pkg::ST_RESET:
          begin
            if (rst_cnt_q == 4'h0)
            begin
              state_q <= idle_reset_pkg::ST_RUN;
              cpu_halt_out <= 1'b0;
            end
          end
          idle_reset_pkg::ST_RUN:
          begin
            if (wr_en && wr_idx == `REG_PWR_CTRL_IDX && w_data_q[`PWR_IDLE_BIT])
            begin
              idle_sel_q <= 1'b1;
              armed_irq_q <= 1'b0;
              state_q <= idle_reset_pkg::ST_ARMED;
            end
          end
          idle_reset_pkg::ST_ARMED:
          begin
            if (irq_wake)
            begin
              armed_irq_q <= 1'b1;
            end
            if (cpu_status_in.instr_done)
            begin
              state_q <= idle_reset_pkg::ST_IDLE;
              cpu_halt_out <= 1'b1;
              wake_blocked_q <= (armed_irq_q || irq_wake) && cpu_status_in.next_single_byte;
            end
          end
          idle_reset_pkg::ST_IDLE:
          begin
            if (irq_wake && !wake_blocked_q)
            begin
              idle_sel_q <= 1'b0;
              cpu_halt_out <= 1'b0;
              wake_irq_out <= 1'b1;
              state_q <= idle_reset_pkg::ST_RUN;
            end
          end
          default:
          begin
            state_q <= idle_reset_pkg::ST_RESET;
          end
        endcase
      end
    end
  end

  // Watchdog; counts in every state so idle cannot hang forever unless disabled
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      wdt_en_q <= 1'(`WDT_CTRL_RST);
      wdt_lock_q <= 1'b0;
      wdt_cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (rst_trig)
      begin
        wdt_en_q <= 1'b1;
        wdt_lock_q <= 1'b0;
        wdt_cnt_q <= '0;
      end
      else
      begin
        wdt_cnt_q <= wdt_en_q ? wdt_cnt_q + WDT_W'(1) : '0;
        if (wr_en && wr_idx == `REG_WDT_CTRL_IDX)
        begin
          if (w_data_q[`WDT_KICK_BIT])
          begin
            wdt_cnt_q <= '0;
          end
          if (!wdt_lock_q)
          begin
            wdt_en_q <= w_data_q[`WDT_EN_BIT];
          end
          // Lock is write-once until the next reset
          wdt_lock_q <= wdt_lock_q | w_data_q[`WDT_LOCK_BIT];
        end
      end
    end
  end

  // Interrupt events
  assign irq_set = {
    (state_q == idle_reset_pkg::ST_RESET) && (rst_cnt_q == 4'h1),
    (state_q == idle_reset_pkg::ST_IDLE) && irq_wake && !wake_blocked_q && !rst_trig,
    (state_q == idle_reset_pkg::ST_ARMED) && cpu_status_in.instr_done && !rst_trig
  };

  // Sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      irq_stat_q <= 3'(`IRQ_RST_VAL);
      irq_mask_q <= 3'(`IRQ_RST_VAL);
      irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_en && wr_idx == `REG_IRQ_STAT_IDX)
      begin
        irq_stat_q <= (irq_stat_q & ~w_data_q[2:0]) | irq_set;
      end
      else
      begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_en && wr_idx == `REG_IRQ_MASK_IDX)
      begin
        irq_mask_q <= w_data_q[2:0];
      end
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// ### verification/idle_reset_ctrl_sva.sv
// Port-level checks of the idle and reset sequencer
module idle_reset_sva #(
  parameter int N_IRQ = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [N_IRQ-1:0] irq_pending_in,
  input wire logic [N_IRQ-1:0] irq_enable_in,
  input wire idle_reset_pkg::cpu_status_t cpu_status_in,
  input wire idle_reset_pkg::reset_sources_t reset_sources_in,
  input wire logic cpu_halt_out,
  input wire logic wake_irq_out,
  input wire logic dev_reset_out,
  input wire logic [15:0] reset_vector_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_any;
  logic done;
  logic hard_src;

  // Enabled request, completion pulse and sources that reset without an enable
  // Supply monitor is left out: software can remove it as a reset source
  assign irq_any = |(irq_pending_in & irq_enable_in);
  assign done = cpu_status_in.instr_done;
  assign hard_src = reset_sources_in.pin | reset_sources_in.flash_error;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_halt_entry;
    $rose(cpu_halt_out) && !dev_reset_out |-> $past(done);
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt without completion");

  // The reset release edge is excluded: halt falls there by design
  property p_idle_holds;
    cpu_halt_out && !dev_reset_out && !$past(dev_reset_out) && !irq_any |=> cpu_halt_out;
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("idle left without cause");

  property p_wake_cause;
    wake_irq_out |-> $past(irq_any);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without enabled request");

  property p_wake_clears;
    wake_irq_out |-> !cpu_halt_out && $past(cpu_halt_out);
  endproperty
  a_wake_clears: assert property (p_wake_clears) else $error("wake did not resume");

  property p_rst_len;
    $rose(dev_reset_out) |-> dev_reset_out [*5] ##1 !dev_reset_out;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset sequence length wrong");

  property p_rst_release;
    $fell(dev_reset_out) |=> $fell(cpu_halt_out);
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("cpu not released");

  property p_src_reset;
    hard_src |=> dev_reset_out && cpu_halt_out;
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("source did not reset");

  property p_vector;
    $fell(dev_reset_out) |-> reset_vector_out == 16'h0000;
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector wrong");
endmodule

bind idle_reset_ctrl idle_reset_sva #(.N_IRQ(N_IRQ)) i_idle_reset_sva (.sys_clk_in, .rst_in, .irq_pending_in,
  .irq_enable_in, .cpu_status_in, .reset_sources_in, .cpu_halt_out, .wake_irq_out, .dev_reset_out, .reset_vector_out);

// ### verification/cpu_model.sv
// Behavioural CPU: instruction completion and interrupt sources
module cpu_model (
  input wire logic clk_in,
  input wire logic wake_in,
  output idle_reset_pkg::cpu_status_t status_out,
  output logic [7:0] irq_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet until the bench asks for something
  initial
  begin
    status_out = '0;
    irq_out = '0;
  end

  // One-cycle completion of the instruction that wrote the idle bit
  // two-byte follow-up normally
  task automatic finish(input logic single);
    status_out <= '{instr_done: 1'h1, next_single_byte: single};
    @(posedge clk_in);
    status_out <= '0;
  endtask

  // Sources keep raising requests while the CPU sleeps
  // peripherals stay live
  task automatic set_irq(input logic [7:0] v);
    irq_out <= v;
  endtask

  // Handler entry takes the request away; its return resumes after the idle write
  // service then resume
  always @(posedge clk_in)
    if (wake_in === 1'h1)
      irq_out <= '0;
endmodule

// ### verification/idle_reset_ctrl_tb_top.sv
// Self-checking bench for the idle and reset controller
module idle_reset_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rst_in, ce_in;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic [7:0] irq_pending_in, irq_enable_in;
  idle_reset_pkg::cpu_status_t cpu_status_in;
  idle_reset_pkg::reset_sources_t reset_sources_in;
  logic cpu_halt_out, wake_irq_out, dev_reset_out, irq_out;
  logic [15:0] reset_vector_out;
  int mismatches = 0;
  int checks_done = 0;
  int wakes = 0;
  // Per source: cause write with its enable, source bit, expected cause
  logic [7:0] en_tab [5] = '{8'h02, 8'h06, 8'h22, 8'h02, 8'h02};
  logic [4:0] src_tab [5] = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h02};
  logic [7:0] exp_tab [5] = '{8'h01, 8'h04, 8'h20, 8'h40, 8'h02};

  // Short watchdog count keeps the timeout scenario brief
  idle_reset_ctrl #(.WDT_TIMEOUT_CYCLES(16)) i_idle_reset_ctrl (.sys_clk_in, .rst_in, .ce_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .irq_pending_in, .irq_enable_in,
    .cpu_status_in, .reset_sources_in, .cpu_halt_out, .wake_irq_out, .dev_reset_out, .reset_vector_out, .irq_out);

  cpu_model i_cpu_model (.clk_in(sys_clk_in), .wake_in(wake_irq_out), .status_out(cpu_status_in),
    .irq_out(irq_pending_in));

  // 50 MHz system clock
  initial
  begin
    sys_clk_in = 1'h0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // Count wake pulses
  always @(posedge sys_clk_in)
    if (wake_irq_out === 1'h1)
      wakes <= wakes + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Write one register by index; bready stays high for the whole run
  task automatic axw(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr_in <= {2'h0, idx, 2'h0};
    s_axi_wdata_in <= {24'h0, d};
    {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h3;
    forever
    begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_bvalid_out) break;
    end
    chk(s_axi_bvalid_out, 1'h1);
    chk(s_axi_bresp_out, er);
  endtask

  task automatic axr(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    s_axi_araddr_in <= {2'h0, idx, 2'h0};
    s_axi_arvalid_in <= 1'h1;
    forever
    begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      if (s_axi_rvalid_out) break;
    end
    chk(s_axi_rvalid_out, 1'h1);
    chk(s_axi_rdata_out, {24'h0, exp});
    chk(s_axi_rresp_out, er);
  endtask

  // Wait out a reset sequence, then stop the watchdog before it fires again
  task automatic recover;
    repeat (2) @(posedge sys_clk_in);
    repeat (60)
    begin
      if (dev_reset_out === 1'h0 && cpu_halt_out === 1'h0) break;
      @(posedge sys_clk_in);
    end
    chk(cpu_halt_out, 1'h0);
    axw(8'h01, 8'h00, 2'h0);
  endtask

  task automatic idle_on(input logic single);
    axw(8'h00, 8'h01, 2'h0);
    i_cpu_model.finish(single);
    repeat (2) @(posedge sys_clk_in);
    chk(cpu_halt_out, 1'h1);
  endtask

  // Hang guard well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    mismatches++;
    conclude;
  end

  initial
  begin
    {rst_in, ce_in, s_axi_wstrb_in, s_axi_bready_in, s_axi_rready_in} = 8'hff;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    {irq_enable_in, reset_sources_in} = '0;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    recover;
    // Reset values, unmapped place, unused top bit
    axr(8'hef, 8'h02, 2'h0);
    axr(8'h00, 8'h00, 2'h0);
    axr(8'h03, 8'h00, 2'h0);
    axr(8'h10, 8'h00, 2'h2);
    axw(8'h10, 8'h01, 2'h2);
    axw(8'hef, 8'h82, 2'h0);
    axr(8'hef, 8'h02, 2'h0);
    // Idle with watchdog off, ignored disabled request, then idle interrupt raised
    axw(8'h02, 8'h07, 2'h0);
    axw(8'h03, 8'h03, 2'h0);
    idle_on(1'h0);
    i_cpu_model.set_irq(8'h01);
    repeat (30) @(posedge sys_clk_in);
    chk(cpu_halt_out, 1'h1);
    chk(irq_out, 1'h1);
    axr(8'h03, 8'h03, 2'h0);
    // Frozen clock enable holds idle even with an enabled request
    ce_in <= 1'h0;
    irq_enable_in <= 8'h01;
    repeat (5) @(posedge sys_clk_in);
    chk(cpu_halt_out, 1'h1);
    ce_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    chk(cpu_halt_out, 1'h0);
    chk(wakes, 1);
    axr(8'h00, 8'h00, 2'h0);
    axr(8'h02, 8'h03, 2'h0);
    axw(8'h03, 8'h00, 2'h0);
    repeat (2) @(posedge sys_clk_in);
    chk(irq_out, 1'h0);
    axw(8'h02, 8'h03, 2'h0);
    axr(8'h02, 8'h00, 2'h0);
    // Request during the idle write before a one-byte opcode: only reset wakes
    axw(8'h00, 8'h01, 2'h0);
    i_cpu_model.set_irq(8'h01);
    i_cpu_model.finish(1'h1);
    repeat (20) @(posedge sys_clk_in);
    chk(cpu_halt_out, 1'h1);
    chk(wakes, 1);
    axw(8'hef, 8'h12, 2'h0);
    i_cpu_model.set_irq(8'h00);
    irq_enable_in <= 8'h00;
    recover;
    axr(8'hef, 8'h10, 2'h0);
    axr(8'h00, 8'h00, 2'h0);
    // Locked watchdog cannot be stopped and ends idle
    axw(8'h01, 8'h07, 2'h0);
    axw(8'h01, 8'h04, 2'h0);
    idle_on(1'h0);
    recover;
    axr(8'hef, 8'h08, 2'h0);
    // Every other reset source, each recorded alone
    for (int i = 0; i < 5; i++)
    begin
      axw(8'hef, en_tab[i], 2'h0);
      reset_sources_in <= src_tab[i];
      @(posedge sys_clk_in);
      reset_sources_in <= '0;
      recover;
      axr(8'hef, exp_tab[i], 2'h0);
    end
    conclude;
  end
endmodule
